// file: rtl/pcst_regs.vh
/*
  Register map, field positions, reset values and timing counts of the
  cable and frame self-test block. Assumes a word-addressed register port.
*/
`ifndef PCST_REGS_VH
`define PCST_REGS_VH

// Register offsets (word index on the plain register port)
`define PCST_CABLE_REG 5'h00
`define PCST_MDIX_REG 5'h01
`define PCST_ST_CTRL_REG 5'h02
`define PCST_CNT_LO_REG 5'h03
`define PCST_CNT_HI_REG 5'h04
`define PCST_ST_STATUS_REG 5'h05
`define PCST_OK_LO_REG 5'h06
`define PCST_OK_HI_REG 5'h07
`define PCST_ERR_LO_REG 5'h08
`define PCST_ERR_HI_REG 5'h09
`define PCST_SFD_LO_REG 5'h0a
`define PCST_SFD_HI_REG 5'h0b
`define PCST_MODE_REG 5'h0c

// Cable test register fields
`define PCST_CABLE_GO_BIT 15
`define PCST_PAIR_LSB 12
`define PCST_RESULT_LSB 8
// Crossover register: bit0 automatic crossover enable
`define PCST_MDIX_AUTO_BIT 0
`define PCST_MDIX_RESET 16'h0001
// Self-test control: bit0 frame count en, bit1 test en, bit2 pgen en, bit3 ext clk
`define PCST_FCNT_EN_BIT 0
`define PCST_ST_EN_BIT 1
`define PCST_PGEN_EN_BIT 2
`define PCST_EXTCLK_BIT 3
`define PCST_DONE_BIT 0

// Cable result codes
`define PCST_RES_NORMAL 2'h0
`define PCST_RES_OPEN 2'h1
`define PCST_RES_SHORT 2'h2
`define PCST_RES_FAIL 2'h3

// Mode strap value selecting the board tree test
`define PCST_TREE_STRAP 4'h4

// Reflection timing: pulse width, listen window (ns)
`define PCST_PULSE_NS 80
`define PCST_LISTEN_NS 2560
`define PCST_CLK_NS 10
`define PCST_REFL_OFFSET 8'h16

`endif

// file: rtl/pcst_self_test.v
/*
  Cable reflectometry test, frame generator/checker over a loopback plug,
  and strapped board tree test. Assumes the analog front end returns a
  sampled echo sign/valid per pair, and that line symbols are synchronous.
*/
// Local design decisions: the address-and-strobe port and the register offsets.
// What the document requires of this block and of its software
// [R01] Reflectometry runs on one selected pair only
// [R02] Positive echo polarity classified as open
// [R03] Software disables auto crossover before test
// [R04] Software soft-resets before and after test
// [R05] Software forces gigabit full duplex slave
// [R06] Pair plus go starts; go self-clears
// [R07] Two-bit result: normal, open or short
// [R08] Eight-bit reflection time for faults
// [R09] Fourth result code means test failed
// [R10] Frame test clock internal unless selected
// [R11] Software disables autoneg, sets duplex, speed
// [R12] Software fixes crossover for slow speeds
// [R13] Software forces master and external loopback
// [R14] Count loaded, then enables in order
// [R15] Done flag and three frame counters
// [R16] Tree mode only when straps read 0100
// [R17] Tree output toggles with ranked pins
// [R18] Board enables reference clock output strap
// [R19] Results held until new test or reset
// [R20] New run clears done and counters
`include "pcst_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module pcst_self_test #(
  parameter TREE_W = 17,
  parameter CNT_W = 16
) (
  // Clock and reset
  input wire mclk_i,
  input wire rstn_i,
  // Register port
  input wire [4:0] addr_i,
  input wire [15:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [15:0] rdata_o,
  // Reflectometry front end
  output reg [3:0] tdr_pulse_o,
  input wire echo_valid_i,
  input wire echo_pos_i,
  // Frame loopback line
  input wire ext_clk_tick_i,
  output reg [7:0] tx_sym_o,
  output reg tx_frame_o,
  input wire [7:0] rx_sym_i,
  input wire rx_frame_i,
  input wire rx_err_i,
  // Board test straps and pins
  input wire [3:0] mode_strap_i,
  input wire refclk_output_strap_i,
  input wire [TREE_W-1:0] tree_pins_i,
  input wire refclk_i,
  output reg refclk_out_tree_pin_o,
  output reg refclk_out_tree_pin_oe_o,
  output wire tree_mode_o
);

  localparam [31:0] PULSE_CYC = (`PCST_PULSE_NS + `PCST_CLK_NS - 1) / `PCST_CLK_NS;
  localparam [31:0] LISTEN_CYC = `PCST_LISTEN_NS / `PCST_CLK_NS;
  localparam [3:0] C_IDLE = 4'h1;
  localparam [3:0] C_PULSE = 4'h2;
  localparam [3:0] C_LISTEN = 4'h4;
  localparam [3:0] C_DONE = 4'h8;
  localparam [3:0] F_IDLE = 4'h1;
  localparam [3:0] F_SEND = 4'h2;
  localparam [3:0] F_WAIT = 4'h4;
  localparam [3:0] F_DONE = 4'h8;
  localparam [7:0] SFD = 8'hd5;
  localparam [4:0] FRAME_LEN = 5'h10;

  // Cable test state
  reg [3:0] cst_q;
  reg go_q;
  reg [1:0] pair_q;
  reg [1:0] result_q;
  reg [7:0] refl_q;
  reg [7:0] tcnt_q;
  reg auto_mdix_q;
  // Frame test state
  reg [3:0] fst_q;
  reg [2:0] en_q;
  reg extclk_q;
  reg [CNT_W-1:0] target_q;
  reg [CNT_W-1:0] sent_q;
  reg [CNT_W-1:0] ok_q;
  reg [CNT_W-1:0] err_q;
  reg [CNT_W-1:0] sfd_q;
  reg [CNT_W-1:0] rxed_q;
  reg [4:0] byte_q;
  reg done_q;
  reg rx_in_q;
  reg rx_bad_q;
  reg rx_first_q;
  reg [7:0] wait_q;
  // Tree mode
  reg tree_q;
  reg strap_taken_q;

  wire cable_wr = wr_i && addr_i == `PCST_CABLE_REG;
  wire start_cable = cable_wr && wdata_i[`PCST_CABLE_GO_BIT] && cst_q == C_IDLE;
  wire ctrl_wr = wr_i && addr_i == `PCST_ST_CTRL_REG;
  // Frame test starts on the pattern enable, last in the sequence
  wire start_frame = ctrl_wr && wdata_i[`PCST_PGEN_EN_BIT] && en_q[1] && en_q[0]; // [R14]
  // Self-test tick: every clock, or the external 125 MHz tick
  wire tick = extclk_q ? ext_clk_tick_i : 1'b1; // [R10]

  // Cable reflectometry sequence
  always @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      cst_q <= C_IDLE;
      go_q <= 1'b0;
      pair_q <= 2'h0;
      result_q <= `PCST_RES_NORMAL;
      refl_q <= 8'h00;
      tcnt_q <= 8'h00;
      tdr_pulse_o <= 4'h0;
    end
    else
    begin
      case (cst_q)
        C_IDLE:
        begin
          if (start_cable)
          begin
            go_q <= 1'b1; // [R06]
            pair_q <= wdata_i[`PCST_PAIR_LSB+1:`PCST_PAIR_LSB];
            tcnt_q <= 8'h00;
            cst_q <= C_PULSE;
          end
        end
        C_PULSE:
        begin
          // Only the chosen pair is driven
          tdr_pulse_o <= 4'h1 << pair_q; // [R01]
          tcnt_q <= tcnt_q + 8'h01;
          if (tcnt_q == PULSE_CYC[7:0])
          begin
            tdr_pulse_o <= 4'h0;
            tcnt_q <= 8'h00;
            cst_q <= C_LISTEN;
          end
        end
        C_LISTEN:
        begin
          tcnt_q <= tcnt_q + 8'h01;
          if (echo_valid_i)
          begin
            // Count includes the fixed path offset, software subtracts it
            refl_q <= tcnt_q + `PCST_REFL_OFFSET; // [R08]
            result_q <= echo_pos_i ? `PCST_RES_OPEN : `PCST_RES_SHORT; // [R02] [R07]
            cst_q <= C_DONE;
          end
          else if (tcnt_q == LISTEN_CYC[7:0] - 8'h01)
          begin
            // No echo inside window: line terminated, or partner active
            result_q <= auto_mdix_q ? `PCST_RES_FAIL : `PCST_RES_NORMAL; // [R09]
            refl_q <= 8'h00;
            cst_q <= C_DONE;
          end
        end
        C_DONE:
        begin
          go_q <= 1'b0; // [R06] [R19]
          cst_q <= C_IDLE;
        end
        default:
          cst_q <= C_IDLE;
      endcase
    end
  end

  // Control registers
  always @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      auto_mdix_q <= |(`PCST_MDIX_RESET & (16'h0001 << `PCST_MDIX_AUTO_BIT));
      en_q <= 3'h0;
      extclk_q <= 1'b0;
      target_q <= {CNT_W{1'b0}};
    end
    else
    begin
      if (wr_i && addr_i == `PCST_MDIX_REG)
        auto_mdix_q <= wdata_i[`PCST_MDIX_AUTO_BIT]; // [R03]
      if (ctrl_wr)
      begin
        en_q <= wdata_i[2:0];
        extclk_q <= wdata_i[`PCST_EXTCLK_BIT]; // [R10]
      end
      if (wr_i && addr_i == `PCST_CNT_LO_REG)
        target_q[7:0] <= wdata_i[7:0];
      if (wr_i && addr_i == `PCST_CNT_HI_REG)
        target_q[CNT_W-1:8] <= wdata_i[CNT_W-9:0];
    end
  end

  // Frame generator and checker
  always @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      fst_q <= F_IDLE;
      sent_q <= {CNT_W{1'b0}};
      ok_q <= {CNT_W{1'b0}};
      err_q <= {CNT_W{1'b0}};
      sfd_q <= {CNT_W{1'b0}};
      rxed_q <= {CNT_W{1'b0}};
      byte_q <= 5'h00;
      done_q <= 1'b0;
      rx_in_q <= 1'b0;
      rx_bad_q <= 1'b0;
      rx_first_q <= 1'b0;
      wait_q <= 8'h00;
      tx_sym_o <= 8'h00;
      tx_frame_o <= 1'b0;
    end
    else if (start_frame)
    begin
      // Fresh run
      done_q <= 1'b0; // [R20]
      ok_q <= {CNT_W{1'b0}};
      err_q <= {CNT_W{1'b0}};
      sfd_q <= {CNT_W{1'b0}};
      sent_q <= {CNT_W{1'b0}};
      rxed_q <= {CNT_W{1'b0}};
      byte_q <= 5'h00;
      fst_q <= F_SEND;
    end
    else if (tick)
    begin
      case (fst_q)
        F_IDLE:
          tx_frame_o <= 1'b0;
        F_SEND:
        begin
          // One idle slot after each frame lets the checker see its end
          tx_frame_o <= byte_q != FRAME_LEN;
          tx_sym_o <= byte_q == 5'h00 ? SFD : {3'h0, byte_q};
          byte_q <= byte_q == FRAME_LEN ? 5'h00 : byte_q + 5'h01;
          if (byte_q == FRAME_LEN - 5'h01)
          begin
            sent_q <= sent_q + 1'b1;
            if (sent_q + 1'b1 == target_q || !en_q[0])
            begin
              wait_q <= 8'h00;
              fst_q <= F_WAIT;
            end
          end
        end
        F_WAIT:
        begin
          tx_frame_o <= 1'b0;
          wait_q <= wait_q + 8'h01;
          if (rxed_q == sent_q || wait_q == 8'hff)
            fst_q <= F_DONE;
        end
        F_DONE:
        begin
          done_q <= 1'b1; // [R15]
          fst_q <= F_IDLE;
        end
        default:
          fst_q <= F_IDLE;
      endcase
      // Receive side checks each looped frame
      rx_in_q <= rx_frame_i;
      if (rx_frame_i && !rx_in_q)
      begin
        rx_first_q <= rx_sym_i == SFD;
        rx_bad_q <= rx_err_i;
      end
      else if (rx_frame_i && rx_err_i)
        rx_bad_q <= 1'b1;
      if (!rx_frame_i && rx_in_q && fst_q != F_IDLE)
      begin
        rxed_q <= rxed_q + 1'b1;
        if (!rx_first_q)
          sfd_q <= sfd_q + 1'b1; // [R15]
        else if (rx_bad_q)
          err_q <= err_q + 1'b1;
        else
          ok_q <= ok_q + 1'b1;
      end
    end
  end

  // Strap capture after reset release; not during synchronous reset
  always @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      tree_q <= 1'b0;
      strap_taken_q <= 1'b0;
    end
    else if (!strap_taken_q)
    begin
      strap_taken_q <= 1'b1;
      tree_q <= mode_strap_i == `PCST_TREE_STRAP; // [R16]
    end
  end
  assign tree_mode_o = tree_q;

  // Chain of NANDs over ranked pins, lowest rank first
  reg tree_out;
  integer i;
  always @*
  begin
    tree_out = 1'b1;
    for (i = 0; i < TREE_W; i = i + 1)
      tree_out = ~(tree_out & tree_pins_i[i]); // [R17]
  end

  // Output pin: tree result in board mode, else reference clock
  always @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      refclk_out_tree_pin_o <= 1'b0;
      refclk_out_tree_pin_oe_o <= 1'b0;
    end
    else
    begin
      refclk_out_tree_pin_o <= tree_q ? tree_out : refclk_i; // [R17]
      refclk_out_tree_pin_oe_o <= refclk_output_strap_i; // [R18]
    end
  end

  // Read port, data one cycle after strobe
  always @(posedge mclk_i)
  begin
    if (!rstn_i)
      rdata_o <= 16'h0000;
    else if (rd_i)
    begin
      case (addr_i)
        `PCST_CABLE_REG: rdata_o <= {go_q, 1'b0, pair_q, 2'h0, result_q, refl_q}; // [R07]
        `PCST_MDIX_REG: rdata_o <= {15'h0000, auto_mdix_q};
        `PCST_ST_CTRL_REG: rdata_o <= {12'h000, extclk_q, en_q};
        `PCST_CNT_LO_REG: rdata_o <= {8'h00, target_q[7:0]};
        `PCST_CNT_HI_REG: rdata_o <= {8'h00, target_q[CNT_W-1:8]};
        `PCST_ST_STATUS_REG: rdata_o <= {15'h0000, done_q};
        `PCST_OK_LO_REG: rdata_o <= {8'h00, ok_q[7:0]};
        `PCST_OK_HI_REG: rdata_o <= {8'h00, ok_q[CNT_W-1:8]};
        `PCST_ERR_LO_REG: rdata_o <= {8'h00, err_q[7:0]};
        `PCST_ERR_HI_REG: rdata_o <= {8'h00, err_q[CNT_W-1:8]};
        `PCST_SFD_LO_REG: rdata_o <= {8'h00, sfd_q[7:0]};
        `PCST_SFD_HI_REG: rdata_o <= {8'h00, sfd_q[CNT_W-1:8]};
        `PCST_MODE_REG: rdata_o <= {15'h0000, tree_q};
        default: rdata_o <= 16'h0000;
      endcase
    end
  end

endmodule

`default_nettype wire

// file: dv/pcst_line_model.sv
/*
  Cable and loopback plug as seen from the line pins.
  Assumes the bench sets fault kind, echo delay and corruption between tests.
*/
`timescale 1ns/1ps
`default_nettype none
module pcst_line_model (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  // Fault 0 none, 1 open, 2 short; corrupt bit0 error, bit1 bad delimiter
  input wire logic [1:0] fault_i,
  input wire logic [7:0] echo_dly_i,
  input wire logic [1:0] corrupt_i,
  // Device pins
  input wire logic [3:0] tdr_pulse_o,
  input wire logic [7:0] tx_sym_o,
  input wire logic tx_frame_o,
  output logic echo_valid_o,
  output logic echo_pos_o,
  output logic [7:0] rx_sym_o,
  output logic rx_frame_o,
  output logic rx_err_o
);
  logic pulse_q;
  logic [7:0] wait_q;
  always_ff @(posedge mclk_i)
  begin
    pulse_q <= |tdr_pulse_o;
    echo_valid_o <= 1'b0;
    rx_frame_o <= tx_frame_o;
    rx_err_o <= tx_frame_o & corrupt_i[0];
    if (!rstn_i)
    begin
      wait_q <= 8'h00;
      echo_pos_o <= 1'b0;
      rx_sym_o <= 8'h00;
    end
    else
    begin
      // Echo returns a set time after the pulse ends
      if (pulse_q && tdr_pulse_o == 4'h0 && fault_i != 2'h0)
        wait_q <= echo_dly_i;
      else if (wait_q != 8'h00)
        wait_q <= wait_q - 8'h01;
      // Polarity wanders outside an echo, so stale values never match
      echo_pos_o <= ~echo_pos_o;
      if (wait_q == 8'h01)
      begin
        echo_valid_o <= 1'b1;
        echo_pos_o <= fault_i == 2'h1;
      end
      if (tx_frame_o)
        rx_sym_o <= (!rx_frame_o && corrupt_i[1]) ? ~tx_sym_o : tx_sym_o;
      else
        rx_sym_o <= ~rx_sym_o;
    end
  end
endmodule
`default_nettype wire

// file: dv/pcst_self_test_props.sv
/*
  Port checker of the self-test block.
  Assumes straps are held steady through each reset release.
*/
`include "pcst_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module pcst_self_test_props (
  // Clock, reset, read side
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic rd_i,
  input wire logic [15:0] rdata_o,
  // Line side
  input wire logic [3:0] tdr_pulse_o,
  input wire logic [7:0] tx_sym_o,
  input wire logic tx_frame_o,
  // Straps and tree
  input wire logic [3:0] mode_strap_i,
  input wire logic refclk_output_strap_i,
  input wire logic refclk_out_tree_pin_oe_o,
  input wire logic tree_mode_o
);
  logic rel_q;
  logic [3:0] strap_q;
  logic [5:0] len_q;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  always_ff @(posedge mclk_i)
  begin
    len_q <= tx_frame_o ? len_q + 6'h01 : 6'h00;
    if (!rstn_i)
      rel_q <= 1'b0;
    else
      rel_q <= 1'b1;
    if (rstn_i && !rel_q)
      strap_q <= mode_strap_i;
  end
  pulse_onehot_a: assert property (tdr_pulse_o != 4'h0 |-> $onehot(tdr_pulse_o))
    else $error("pulse on several pairs");
  pulse_len_a: assert property ($rose(|tdr_pulse_o) |-> ##1 $stable(tdr_pulse_o) [*7]
    ##1 tdr_pulse_o == 4'h0) else $error("pulse not eight cycles");
  rdata_hold_a: assert property (!rd_i |=> $stable(rdata_o))
    else $error("read data moved without a read");
  frame_sfd_a: assert property ($rose(tx_frame_o) |-> tx_sym_o == 8'hd5)
    else $error("frame without delimiter");
  frame_len_a: assert property ($fell(tx_frame_o) |-> len_q == 6'h10)
    else $error("frame length wrong");
  tree_strap_a: assert property (rel_q |=> tree_mode_o == (strap_q == `PCST_TREE_STRAP))
    else $error("tree mode does not follow straps");
  tree_hold_a: assert property ($past(rel_q) |-> $stable(tree_mode_o))
    else $error("tree mode changed without reset");
  tree_oe_a: assert property (tree_mode_o |-> refclk_out_tree_pin_oe_o == refclk_output_strap_i)
    else $error("tree pin enable wrong");
  cover property ($rose(|tdr_pulse_o));
  cover property ($fell(tx_frame_o));
  cover property ($rose(tree_mode_o));
endmodule
bind pcst_self_test pcst_self_test_props pcst_self_test_props_inst (.mclk_i(mclk_i),
  .rstn_i(rstn_i), .rd_i(rd_i), .rdata_o(rdata_o), .tdr_pulse_o(tdr_pulse_o),
  .tx_sym_o(tx_sym_o), .tx_frame_o(tx_frame_o), .mode_strap_i(mode_strap_i),
  .refclk_output_strap_i(refclk_output_strap_i),
  .refclk_out_tree_pin_oe_o(refclk_out_tree_pin_oe_o), .tree_mode_o(tree_mode_o));
`default_nettype wire

// file: dv/pcst_self_test_test.sv
/*
  Bench: register tasks, cable, frame and tree scenarios.
  Assumes the line model and checker are compiled before it.
*/
`include "pcst_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module pcst_self_test_test;
  logic mclk_i = 0, rstn_i = 0, wr_i = 0, rd_i = 0, tick = 0, strap_oe = 1;
  logic [4:0] addr_i = 0;
  logic [15:0] wdata_i = 0, v, r;
  logic [3:0] strap = 0, last_p = 0;
  logic [16:0] pins = 0;
  logic [1:0] fault = 0, corrupt = 0;
  logic [7:0] dly = 8'h10;
  logic p_q = 0, f_q = 0, t0;
  int err_count = 0, checks = 0, rises = 0, txr = 0, n0, i;
  wire [15:0] rdata;
  wire [3:0] pulse;
  wire [7:0] txs, rxs;
  wire ev, ep, txf, rxf, rxe, tree_out, tree_oe, tree_mode;
  pcst_self_test pcst_self_test_inst (.mclk_i(mclk_i), .rstn_i(rstn_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata), .tdr_pulse_o(pulse),
    .echo_valid_i(ev), .echo_pos_i(ep), .ext_clk_tick_i(tick), .tx_sym_o(txs),
    .tx_frame_o(txf), .rx_sym_i(rxs), .rx_frame_i(rxf), .rx_err_i(rxe),
    .mode_strap_i(strap), .refclk_output_strap_i(strap_oe), .tree_pins_i(pins),
    .refclk_i(1'b0), .refclk_out_tree_pin_o(tree_out),
    .refclk_out_tree_pin_oe_o(tree_oe), .tree_mode_o(tree_mode));
  pcst_line_model pcst_line_model_inst (.mclk_i(mclk_i), .rstn_i(rstn_i), .fault_i(fault),
    .echo_dly_i(dly), .corrupt_i(corrupt), .tdr_pulse_o(pulse), .tx_sym_o(txs),
    .tx_frame_o(txf), .echo_valid_o(ev), .echo_pos_o(ep), .rx_sym_o(rxs),
    .rx_frame_o(rxf), .rx_err_o(rxe));
  initial
    forever #5 mclk_i = ~mclk_i;
  // Pulse and frame starts seen on the line
  always @(posedge mclk_i)
  begin
    p_q <= |pulse;
    f_q <= txf;
    if (|pulse && !p_q)
    begin
      rises <= rises + 1;
      last_p <= pulse;
    end
    if (txf && !f_q)
      txr <= txr + 1;
  end
  task conclude;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task chk(input string n, input [15:0] e, input [15:0] g);
    checks++;
    if (g !== e)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task wr(input [4:0] a, input [15:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask
  task rd(input [4:0] a, output [15:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    @(posedge mclk_i);
    d = rdata;
  endtask
  task rc(input string n, input [4:0] a, input [15:0] e);
    rd(a, r);
    chk(n, e, r);
  endtask
  task rst_run(input [3:0] s);
    @(posedge mclk_i);
    strap <= s;
    rstn_i <= 1'b0;
    repeat (8) @(posedge mclk_i);
    rstn_i <= 1'b1;
  endtask
  // Second go lands while busy and must be ignored
  // Link taken as a forced gigabit full-duplex slave here
  task cable(input [1:0] p, input [1:0] f, input [7:0] d, input [1:0] e);
    fault <= f;
    dly <= d;
    n0 = rises;
    wr(`PCST_CABLE_REG, {2'b10, p, 12'h000});
    wr(`PCST_CABLE_REG, {2'b10, ~p, 12'h000});
    v = 16'h8000;
    repeat (200) if (v[15] !== 1'b0) rd(`PCST_CABLE_REG, v);
    chk("go", 16'h0000, {15'h0, v[15]});
    chk("result", {14'h0, e}, {14'h0, v[9:8]});
    chk("pulses", 16'h0001, 16'(rises - n0));
    chk("pair", 16'h0001 << p, {12'h0, last_p});
  endtask
  task run(input [3:0] b, input [7:0] n, input [1:0] c, input [23:0] ex);
    corrupt <= c;
    wr(`PCST_CNT_LO_REG, {8'h00, n});
    wr(`PCST_CNT_HI_REG, 16'h0000);
    wr(`PCST_ST_CTRL_REG, {12'h0, b | 4'h1});
    wr(`PCST_ST_CTRL_REG, {12'h0, b | 4'h3});
    wr(`PCST_ST_CTRL_REG, {12'h0, b | 4'h7});
    rc("done", `PCST_ST_STATUS_REG, 16'h0000);
    if (b[3])
    begin
      n0 = txr;
      repeat (300) @(posedge mclk_i);
      rc("ext done", `PCST_ST_STATUS_REG, 16'h0000);
      chk("ext frames", 16'h0000, 16'(txr - n0));
      tick <= 1'b1;
    end
    v = 16'h0000;
    repeat (300) if (v[0] !== 1'b1) rd(`PCST_ST_STATUS_REG, v);
    chk("done", 16'h0001, {15'h0, v[0]});
    for (i = 0; i < 6; i++)
      rc("count", 5'h06 + i[4:0], i[0] ? 16'h0 : {8'h0, ex[23 - 8 * (i / 2) -: 8]});
  endtask
  initial
  begin
    rst_run(4'h0);
    rc("cable", `PCST_CABLE_REG, 16'h0000);
    rc("mdix", `PCST_MDIX_REG, `PCST_MDIX_RESET);
    rc("unmapped", 5'h1f, 16'h0000);
    cable(2'h2, 2'h0, 8'd20, `PCST_RES_FAIL);
    wr(`PCST_MDIX_REG, 16'h0000);
    cable(2'h0, 2'h1, 8'd20, `PCST_RES_OPEN);
    r = v;
    cable(2'h3, 2'h2, 8'd60, `PCST_RES_SHORT);
    chk("distance", 16'd40, {8'h0, v[7:0] - r[7:0]});
    cable(2'h1, 2'h0, 8'd20, `PCST_RES_NORMAL);
    repeat (50) @(posedge mclk_i);
    rc("held", `PCST_CABLE_REG, v);
    run(4'h0, 8'd3, 2'h0, {8'd3, 8'd0, 8'd0});
    run(4'h0, 8'd2, 2'h1, {8'd0, 8'd2, 8'd0});
    run(4'h0, 8'd1, 2'h3, {8'd0, 8'd0, 8'd1});
    run(4'h8, 8'd2, 2'h0, {8'd2, 8'd0, 8'd0});
    rst_run(`PCST_TREE_STRAP);
    repeat (3) @(posedge mclk_i);
    chk("tree mode", 16'h0001, {15'h0, tree_mode});
    chk("tree oe", {15'h0, strap_oe}, {15'h0, tree_oe});
    for (i = 0; i < 17; i++)
    begin
      pins <= ~17'h0 << (i + 1);
      repeat (4) @(posedge mclk_i);
      t0 = tree_out;
      pins[i] <= 1'b1;
      repeat (4) @(posedge mclk_i);
      chk("tree out", {15'h0, ~t0}, {15'h0, tree_out});
    end
    rst_run(4'h0);
    repeat (3) @(posedge mclk_i);
    chk("tree mode", 16'h0000, {15'h0, tree_mode});
    conclude;
  end
  initial
  begin
    repeat (30000) @(posedge mclk_i);
    err_count++;
    conclude;
  end
endmodule
`default_nettype wire
